// ==== hdlc_dma_cfg_map.vh ====
// Register map constants for the HDLC DMA configuration block.
// Assumes 16-bit registers at byte offsets on the device's register port.
`ifndef HDLC_DMA_CFG_MAP_VH
`define HDLC_DMA_CFG_MAP_VH

// ==========
// Offsets
`define OFS_RX_FREE_QUEUE_BASE_LO 16'h0700
`define OFS_RX_FREE_QUEUE_BASE_HI 16'h0704
`define OFS_RX_FREE_QUEUE_END 16'h0708
`define OFS_RX_FREE_QUEUE_SMALL_START 16'h070c
`define OFS_RX_FREE_LARGE_HOST_WPTR 16'h0710
`define OFS_RX_FREE_SMALL_HOST_WPTR 16'h0714
`define OFS_RX_FREE_LARGE_DMA_RPTR 16'h0718
`define OFS_RX_FREE_SMALL_DMA_RPTR 16'h071c
`define OFS_RX_DONE_QUEUE_BASE_LO 16'h0730
`define OFS_RX_DONE_QUEUE_BASE_HI 16'h0734
`define OFS_RX_DONE_QUEUE_END 16'h0738
`define OFS_RX_DONE_HOST_RPTR 16'h073c
`define OFS_RX_DONE_DMA_WPTR 16'h0740
`define OFS_RX_DONE_FLUSH_TIMER 16'h0744
`define OFS_RX_DESCRIPTOR_BASE_LO 16'h0750
`define OFS_RX_DESCRIPTOR_BASE_HI 16'h0754
`define OFS_RX_DMA_CFG_SELECT 16'h0770
`define OFS_RX_DMA_CFG_DATA 16'h0774
`define OFS_RX_DMA_QUEUES_CONTROL 16'h0780
`define OFS_RX_LARGE_BUFFER_SIZE 16'h0790
`define OFS_RX_SMALL_BUFFER_SIZE 16'h0794
`define OFS_TX_PENDING_QUEUE_BASE_LO 16'h0800
`define OFS_TX_PENDING_QUEUE_BASE_HI 16'h0804
`define OFS_TX_PENDING_QUEUE_END 16'h0808
`define OFS_TX_PENDING_HOST_WPTR 16'h080c
`define OFS_TX_PENDING_DMA_RPTR 16'h0810
`define OFS_TX_DONE_QUEUE_BASE_LO 16'h0830
`define OFS_TX_DONE_QUEUE_BASE_HI 16'h0834
`define OFS_TX_DONE_QUEUE_END 16'h0838
`define OFS_TX_DONE_HOST_RPTR 16'h083c
`define OFS_TX_DONE_DMA_WPTR 16'h0840
`define OFS_TX_DONE_FLUSH_TIMER 16'h0844
`define OFS_TX_DESCRIPTOR_BASE_LO 16'h0850
`define OFS_TX_DESCRIPTOR_BASE_HI 16'h0854
`define OFS_TX_DMA_CFG_SELECT 16'h0870
`define OFS_TX_DMA_CFG_DATA 16'h0874
`define OFS_TX_QUEUES_FIFO_CONTROL 16'h0880
`define OFS_TX_BLOCK_NEXT_LINK 16'h0994
`define OFS_TX_WATERMARK_INDIRECT_SELECT 16'h09a0
`define OFS_TX_WATERMARK_DATA 16'h09a4
`define OFS_MASTER_CONTROL_REG 16'h0010

// ==========
// Direct register window
`define WIN_BASE 16'h0700
`define WIN_WORDS 128

// ==========
// Field positions and widths
`define SEL_CHANNEL_MSB 7
`define SEL_RW_BIT 14
`define SEL_BUSY_BIT 15
`define LOW_MARK_W 10
`define LINK_W 10
`define SIZE_W 13
`define MC_RX_EN_BIT 0
`define MC_TX_EN_BIT 1
`define MC_RX_BURST_LSB 2
`define MC_TX_BURST_LSB 4

// ==========
// Reset values
`define RST_REG16 16'h0000
`define RST_MASTER_CONTROL 16'h0000
`define RST_SELECT 16'h0000

// ==========
// Burst lengths in dwords
`define BURST_DEFAULT 9'h020
`define BURST_SEL1 9'h040
`define BURST_SEL2 9'h080
`define BURST_SEL3 9'h100

`endif

// ==== hdlc_dma_cfg.v ====
// Configuration core of the HDLC packet DMA: register file, queue
// pointers, transmit low-mark RAM with indirect access, fetch FIFO.
// Assumes a synchronous 16-bit register port on clk and DMA engines
// that pulse pointer advances and report transmit FIFO levels on clk.
`timescale 1ns/100ps
`include "hdlc_dma_cfg_map.vh"

// ==========
// Fetch request FIFO
module fetch_fifo #(
   parameter W = 8,
   parameter D = 8,
   parameter AW = 3
) (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Fill side
   input wire in_valid,
   input wire [W-1:0] in_data,
   output reg in_ready,
   // Drain side
   output reg out_valid,
   output wire [W-1:0] out_data,
   input wire out_ready
);
   localparam [AW:0] DEPTH_C = D;
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] cnt_r;
   reg [AW:0] cnt_nxt;
   wire push;
   wire pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr_r];

   always @* begin
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - {{AW{1'b0}}, 1'b1};
      end
   end

   // Flags are registered so both handshake outputs come from flops
   always @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            mem[wr_ptr_r] <= in_data;
            wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         cnt_r <= cnt_nxt;
         in_ready <= (cnt_nxt != DEPTH_C);
         out_valid <= (cnt_nxt != {(AW+1){1'b0}});
      end
   end
endmodule

// ==========
// Configuration top
// Functional notes
// - Next-block link is ten bits, never self
// - Channel selector 00h..FFh is channel 1..256
// - Control bit one reads low mark, busy
// - Control bit zero writes data into RAM
// - Bit 15 busy, read only, during access
// - Level at low mark triggers data fetch
// - Both DMA enables clear after reset
// - Burst 32 dwords default, else 64/128/256
// - Receive and transmit paths fully independent
// - Descriptor spaces shareable by programmable bases
// - DMA fills descriptor per free buffer
// - Large and small sizes, 13-bit fields
// - Separate large and small free pointers
// - Done queues, pointers and flush timers
// - Pending queue host write, DMA read
// - Base addresses split into two words
// - Size field counts bytes 0..8191
module hdlc_dma_cfg #(
   parameter CHANNELS = 256,
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Register port
   input wire [15:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   output reg reg_rdata_valid,
   // Pointer advances from the DMA engines
   input wire rx_free_large_adv,
   input wire rx_free_small_adv,
   input wire rx_done_adv,
   input wire tx_done_adv,
   input wire tx_pending_adv,
   // Control outputs
   output reg rx_dma_enable_bit,
   output reg tx_dma_enable_bit,
   output reg [8:0] rx_burst_dwords,
   output reg [8:0] tx_burst_dwords,
   output reg [12:0] rx_large_size,
   output reg [12:0] rx_small_size,
   output reg [31:0] rx_desc_base,
   output reg [31:0] tx_desc_base,
   output reg [9:0] next_block_link,
   // Transmit FIFO level reports
   input wire tx_level_valid,
   input wire [7:0] tx_level_ch,
   input wire [9:0] tx_level_blocks,
   output wire tx_level_ready,
   // Fetch requests to the transmit DMA
   output wire fetch_valid,
   output wire [7:0] fetch_ch,
   input wire fetch_ready
);
   localparam [1:0] IA_IDLE = 2'd0;
   localparam [1:0] IA_RUN = 2'd1;

   reg [15:0] cfg_r [0:`WIN_WORDS-1];
   reg [`LOW_MARK_W-1:0] low_mark_ram [0:CHANNELS-1];
   reg [15:0] master_control_reg_r;
   reg [`LINK_W-1:0] link_r;
   reg [7:0] channel_selector_r;
   reg indirect_read_write_ctl_r;
   reg indirect_busy_flag_r;
   reg [1:0] ia_state_r;
   reg [`LOW_MARK_W-1:0] tx_low_mark_value_r;
   reg [15:0] rd_nxt;
   wire [6:0] widx;
   wire in_win;
   wire [`LOW_MARK_W-1:0] cur_mark;
   wire fetch_push;
   integer i;

   assign widx = reg_addr[8:2] - 7'h40;
   assign in_win = is_direct(reg_addr);

   // ==========
   // Helpers
   function is_direct;
      input [15:0] a;
      begin
         case (a)
            `OFS_RX_FREE_QUEUE_BASE_LO, `OFS_RX_FREE_QUEUE_BASE_HI,
            `OFS_RX_FREE_QUEUE_END, `OFS_RX_FREE_QUEUE_SMALL_START,
            `OFS_RX_FREE_LARGE_HOST_WPTR, `OFS_RX_FREE_SMALL_HOST_WPTR,
            `OFS_RX_FREE_LARGE_DMA_RPTR, `OFS_RX_FREE_SMALL_DMA_RPTR,
            `OFS_RX_DONE_QUEUE_BASE_LO, `OFS_RX_DONE_QUEUE_BASE_HI,
            `OFS_RX_DONE_QUEUE_END, `OFS_RX_DONE_HOST_RPTR,
            `OFS_RX_DONE_DMA_WPTR, `OFS_RX_DONE_FLUSH_TIMER,
            `OFS_RX_DESCRIPTOR_BASE_LO, `OFS_RX_DESCRIPTOR_BASE_HI,
            `OFS_RX_DMA_CFG_SELECT, `OFS_RX_DMA_CFG_DATA,
            `OFS_RX_DMA_QUEUES_CONTROL, `OFS_RX_LARGE_BUFFER_SIZE,
            `OFS_RX_SMALL_BUFFER_SIZE, `OFS_TX_PENDING_QUEUE_BASE_LO,
            `OFS_TX_PENDING_QUEUE_BASE_HI, `OFS_TX_PENDING_QUEUE_END,
            `OFS_TX_PENDING_HOST_WPTR, `OFS_TX_PENDING_DMA_RPTR,
            `OFS_TX_DONE_QUEUE_BASE_LO, `OFS_TX_DONE_QUEUE_BASE_HI,
            `OFS_TX_DONE_QUEUE_END, `OFS_TX_DONE_HOST_RPTR,
            `OFS_TX_DONE_DMA_WPTR, `OFS_TX_DONE_FLUSH_TIMER,
            `OFS_TX_DESCRIPTOR_BASE_LO, `OFS_TX_DESCRIPTOR_BASE_HI,
            `OFS_TX_DMA_CFG_SELECT, `OFS_TX_DMA_CFG_DATA,
            `OFS_TX_QUEUES_FIFO_CONTROL: is_direct = 1'b1;
            default: is_direct = 1'b0;
         endcase
      end
   endfunction

   function [6:0] idx;
      input [15:0] a;
      begin
         idx = a[8:2] - 7'h40;
      end
   endfunction

   // Size registers keep only the 13-bit byte count
   function [15:0] field_mask;
      input [15:0] a;
      begin
         if (a == `OFS_RX_LARGE_BUFFER_SIZE || a == `OFS_RX_SMALL_BUFFER_SIZE) begin
            field_mask = {{(16-`SIZE_W){1'b0}}, {`SIZE_W{1'b1}}};
         end else begin
            field_mask = 16'hffff;
         end
      end
   endfunction

   // Wraps to zero after the queue's end entry
   function [15:0] next_ptr;
      input [15:0] p;
      input [15:0] e;
      begin
         if (p == e) begin
            next_ptr = 16'h0000;
         end else begin
            next_ptr = p + 16'h0001;
         end
      end
   endfunction

   function [8:0] burst_len;
      input [1:0] sel;
      begin
         case (sel)
            2'b01: burst_len = `BURST_SEL1;
            2'b10: burst_len = `BURST_SEL2;
            2'b11: burst_len = `BURST_SEL3;
            default: burst_len = `BURST_DEFAULT;
         endcase
      end
   endfunction

   // ==========
   // Direct register file and queue pointers
   // A DMA advance beats a host write to the same pointer in one cycle.
   always @(posedge clk) begin
      if (sys_rst) begin
         for (i = 0; i < `WIN_WORDS; i = i + 1) begin
            cfg_r[i] <= `RST_REG16;
         end
      end else begin
         if (reg_wr && in_win) begin
            cfg_r[widx] <= reg_wdata & field_mask(reg_addr);
         end
         if (rx_free_large_adv) begin
            cfg_r[idx(`OFS_RX_FREE_LARGE_DMA_RPTR)] <= next_ptr(
               cfg_r[idx(`OFS_RX_FREE_LARGE_DMA_RPTR)],
               cfg_r[idx(`OFS_RX_FREE_QUEUE_END)]);
         end
         if (rx_free_small_adv) begin
            cfg_r[idx(`OFS_RX_FREE_SMALL_DMA_RPTR)] <= next_ptr(
               cfg_r[idx(`OFS_RX_FREE_SMALL_DMA_RPTR)],
               cfg_r[idx(`OFS_RX_FREE_QUEUE_END)]);
         end
         if (rx_done_adv) begin
            cfg_r[idx(`OFS_RX_DONE_DMA_WPTR)] <= next_ptr(
               cfg_r[idx(`OFS_RX_DONE_DMA_WPTR)],
               cfg_r[idx(`OFS_RX_DONE_QUEUE_END)]);
         end
         if (tx_done_adv) begin
            cfg_r[idx(`OFS_TX_DONE_DMA_WPTR)] <= next_ptr(
               cfg_r[idx(`OFS_TX_DONE_DMA_WPTR)],
               cfg_r[idx(`OFS_TX_DONE_QUEUE_END)]);
         end
         if (tx_pending_adv) begin
            cfg_r[idx(`OFS_TX_PENDING_DMA_RPTR)] <= next_ptr(
               cfg_r[idx(`OFS_TX_PENDING_DMA_RPTR)],
               cfg_r[idx(`OFS_TX_PENDING_QUEUE_END)]);
         end
      end
   end

   // ==========
   // Master control and block link
   always @(posedge clk) begin
      if (sys_rst) begin
         master_control_reg_r <= `RST_MASTER_CONTROL;
         link_r <= {`LINK_W{1'b0}};
      end else begin
         if (reg_wr && reg_addr == `OFS_MASTER_CONTROL_REG) begin
            master_control_reg_r <= reg_wdata;
         end
         if (reg_wr && reg_addr == `OFS_TX_BLOCK_NEXT_LINK) begin
            link_r <= reg_wdata[`LINK_W-1:0];
         end
      end
   end

   // ==========
   // Indirect low-mark access
   // Select writes while busy are dropped so a running access stays intact.
   always @(posedge clk) begin
      if (sys_rst) begin
         channel_selector_r <= 8'h00;
         indirect_read_write_ctl_r <= 1'b0;
         indirect_busy_flag_r <= 1'b0;
         ia_state_r <= IA_IDLE;
         tx_low_mark_value_r <= {`LOW_MARK_W{1'b0}};
      end else begin
         case (ia_state_r)
            IA_IDLE: begin
               if (reg_wr && reg_addr == `OFS_TX_WATERMARK_DATA) begin
                  tx_low_mark_value_r <= reg_wdata[`LOW_MARK_W-1:0];
               end
               if (reg_wr && reg_addr == `OFS_TX_WATERMARK_INDIRECT_SELECT) begin
                  channel_selector_r <= reg_wdata[`SEL_CHANNEL_MSB:0];
                  indirect_read_write_ctl_r <= reg_wdata[`SEL_RW_BIT];
                  indirect_busy_flag_r <= 1'b1;
                  ia_state_r <= IA_RUN;
               end
            end
            IA_RUN: begin
               if (indirect_read_write_ctl_r) begin
                  tx_low_mark_value_r <= low_mark_ram[channel_selector_r];
               end else begin
                  low_mark_ram[channel_selector_r] <= tx_low_mark_value_r;
               end
               indirect_busy_flag_r <= 1'b0;
               ia_state_r <= IA_IDLE;
            end
            default: begin
               indirect_busy_flag_r <= 1'b0;
               ia_state_r <= IA_IDLE;
            end
         endcase
      end
   end

   // ==========
   // Read mux
   always @* begin
      rd_nxt = 16'h0000;
      if (in_win) begin
         rd_nxt = cfg_r[widx];
      end else begin
         case (reg_addr)
            `OFS_MASTER_CONTROL_REG: rd_nxt = master_control_reg_r;
            `OFS_TX_BLOCK_NEXT_LINK: rd_nxt = {{(16-`LINK_W){1'b0}}, link_r};
            `OFS_TX_WATERMARK_INDIRECT_SELECT: begin
               rd_nxt = {indirect_busy_flag_r, indirect_read_write_ctl_r, 6'h00, channel_selector_r};
            end
            `OFS_TX_WATERMARK_DATA: rd_nxt = {{(16-`LOW_MARK_W){1'b0}}, tx_low_mark_value_r};
            default: rd_nxt = 16'h0000;
         endcase
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
         reg_rdata_valid <= 1'b0;
      end else begin
         reg_rdata_valid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rd_nxt;
         end
      end
   end

   // ==========
   // Registered control outputs
   always @(posedge clk) begin
      if (sys_rst) begin
         rx_dma_enable_bit <= 1'b0;
         tx_dma_enable_bit <= 1'b0;
         rx_burst_dwords <= `BURST_DEFAULT;
         tx_burst_dwords <= `BURST_DEFAULT;
         rx_large_size <= {`SIZE_W{1'b0}};
         rx_small_size <= {`SIZE_W{1'b0}};
         rx_desc_base <= 32'h00000000;
         tx_desc_base <= 32'h00000000;
         next_block_link <= {`LINK_W{1'b0}};
      end else begin
         rx_dma_enable_bit <= master_control_reg_r[`MC_RX_EN_BIT];
         tx_dma_enable_bit <= master_control_reg_r[`MC_TX_EN_BIT];
         rx_burst_dwords <= burst_len(master_control_reg_r[`MC_RX_BURST_LSB+1:`MC_RX_BURST_LSB]);
         tx_burst_dwords <= burst_len(master_control_reg_r[`MC_TX_BURST_LSB+1:`MC_TX_BURST_LSB]);
         rx_large_size <= cfg_r[idx(`OFS_RX_LARGE_BUFFER_SIZE)][`SIZE_W-1:0];
         rx_small_size <= cfg_r[idx(`OFS_RX_SMALL_BUFFER_SIZE)][`SIZE_W-1:0];
         rx_desc_base <= {cfg_r[idx(`OFS_RX_DESCRIPTOR_BASE_HI)],
                          cfg_r[idx(`OFS_RX_DESCRIPTOR_BASE_LO)]};
         tx_desc_base <= {cfg_r[idx(`OFS_TX_DESCRIPTOR_BASE_HI)],
                          cfg_r[idx(`OFS_TX_DESCRIPTOR_BASE_LO)]};
         next_block_link <= link_r;
      end
   end

   // ==========
   // Low-mark compare feeding the fetch FIFO
   // A zero mark is illegal and never fires, so a blank RAM stays quiet.
   assign cur_mark = low_mark_ram[tx_level_ch];
   assign fetch_push = tx_level_valid && tx_dma_enable_bit && cur_mark != {`LOW_MARK_W{1'b0}} &&
                       tx_level_blocks <= cur_mark;

   fetch_fifo #(
      .W(8),
      .D(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fetch_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(fetch_push),
      .in_data(tx_level_ch),
      .in_ready(tx_level_ready),
      .out_valid(fetch_valid),
      .out_data(fetch_ch),
      .out_ready(fetch_ready)
   );
endmodule

// ==== hdlc_dma_cfg_properties.sv ====
// Port-level checker for the HDLC DMA configuration core.
// Assumes binding to hdlc_dma_cfg with offsets as in its map header.
`timescale 1ns/100ps
module hdlc_dma_cfg_checker (
   // Clock and reset
   input logic clk,
   input logic sys_rst,
   // Register port
   input logic [15:0] reg_addr,
   input logic [15:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   input logic [15:0] reg_rdata,
   input logic reg_rdata_valid,
   // Control outputs
   input logic rx_dma_enable_bit,
   input logic tx_dma_enable_bit,
   input logic [8:0] rx_burst_dwords,
   input logic [8:0] tx_burst_dwords,
   input logic [12:0] rx_large_size,
   input logic [31:0] rx_desc_base,
   input logic [31:0] tx_desc_base,
   input logic [9:0] next_block_link,
   // Level reports and fetches
   input logic tx_level_valid,
   input logic tx_level_ready,
   input logic fetch_valid,
   input logic [7:0] fetch_ch,
   input logic fetch_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========
   // Indirect access steps
   sequence s_sel_wr;
      reg_wr && reg_addr == 16'h09a0 && !$past(reg_wr && reg_addr == 16'h09a0);
   endsequence
   sequence s_sel_rd;
      reg_rd && reg_addr == 16'h09a0;
   endsequence
   property p_busy_set;
      s_sel_wr ##1 s_sel_rd |=> reg_rdata[15];
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("busy flag not seen during access");
   property p_busy_clr;
      s_sel_wr ##2 s_sel_rd |=> !reg_rdata[15];
   endproperty
   a_busy_clr: assert property (p_busy_clr) else $error("busy flag not cleared");
   property p_rd_answer;
      reg_rdata_valid == $past(reg_rd);
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer timing off");
   // Reset is the very condition here, so it must not disable
   property p_reset_off;
      @(posedge clk) disable iff (1'b0)
      sys_rst |=> !rx_dma_enable_bit && !tx_dma_enable_bit && rx_burst_dwords == 9'h020 && tx_burst_dwords == 9'h020;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("dma not off after reset");
   property p_burst;
      reg_wr && reg_addr == 16'h0010 |-> ##2 tx_burst_dwords == (9'h020 << $past(reg_wdata[5:4], 2))
         && rx_burst_dwords == (9'h020 << $past(reg_wdata[3:2], 2)) && tx_dma_enable_bit == $past(reg_wdata[1], 2);
   endproperty
   a_burst: assert property (p_burst) else $error("burst or enable mismatch");
   property p_size;
      reg_wr && reg_addr == 16'h0790 |-> ##2 rx_large_size == $past(reg_wdata[12:0], 2);
   endproperty
   a_size: assert property (p_size) else $error("large size mismatch");
   property p_indep;
      reg_wr && reg_addr == 16'h0790 |=> $stable(tx_desc_base) && $stable(next_block_link);
   endproperty
   a_indep: assert property (p_indep) else $error("receive write moved transmit state");
   property p_base_hi;
      reg_wr && reg_addr == 16'h0754 |-> ##2 rx_desc_base[31:16] == $past(reg_wdata, 2);
   endproperty
   a_base_hi: assert property (p_base_hi) else $error("upper base word mismatch");
   property p_link;
      reg_wr && reg_addr == 16'h0994 |-> ##2 next_block_link == $past(reg_wdata[9:0], 2);
   endproperty
   a_link: assert property (p_link) else $error("link value mismatch");
   property p_fetch_hold;
      fetch_valid && !fetch_ready |=> fetch_valid && $stable(fetch_ch);
   endproperty
   a_fetch_hold: assert property (p_fetch_hold) else $error("fetch request dropped while stalled");
   property p_no_fetch;
      tx_level_valid && tx_level_ready && !tx_dma_enable_bit && !fetch_valid |=> !fetch_valid;
   endproperty
   a_no_fetch: assert property (p_no_fetch) else $error("fetch while transmit dma off");
endmodule

bind hdlc_dma_cfg hdlc_dma_cfg_checker hdlc_dma_cfg_checker_inst (.*);

// ==== fetch_sink.sv ====
// Transmit DMA stand-in that takes fetch requests.
// Assumes the bench sets the pace; collected channels are read back hierarchically.
`timescale 1ns/100ps
module fetch_sink (
   // Clock and reset
   input logic clk,
   input logic sys_rst,
   // Fetch requests
   input logic fetch_valid,
   input logic [7:0] fetch_ch,
   output logic fetch_ready,
   // Pace: 0 prompt, 1 every other cycle, 2 stalled
   input logic [1:0] pace
);
   logic [7:0] got [$];
   logic tick;
   always @(posedge clk) begin
      if (sys_rst) begin
         tick <= 1'b0;
         fetch_ready <= 1'b0;
      end else begin
         tick <= ~tick;
         if (fetch_valid && fetch_ready) begin
            got.push_back(fetch_ch);
         end
         fetch_ready <= (pace == 2'd0) || (pace == 2'd1 && tick);
      end
   end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the HDLC DMA configuration core.
// Assumes fetch_sink as the transmit DMA stand-in and the bound checker.
`timescale 1ns/100ps
module tb_top;
   logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, tx_level_valid = 1'b0, ten = 1'b0;
   logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, v [39], d;
   logic [4:0] adv = 5'h00;
   logic [7:0] tx_level_ch = 8'h00, ca, cb;
   logic [9:0] tx_level_blocks = 10'h000, ma;
   logic [1:0] pace = 2'd0;
   wire [15:0] reg_rdata;
   wire reg_rdata_valid, rx_dma_enable_bit, tx_dma_enable_bit, tx_level_ready, fetch_valid, fetch_ready;
   wire [8:0] rx_burst_dwords, tx_burst_dwords;
   wire [12:0] rx_large_size, rx_small_size;
   wire [31:0] rx_desc_base, tx_desc_base;
   wire [9:0] next_block_link;
   wire [7:0] fetch_ch;
   int seed = 32'hbabe, bad_count = 0, checked = 0, n;
   logic [7:0] exp_q [$];
   localparam logic [15:0] OFS [39] = '{16'h0700, 16'h0704, 16'h0708, 16'h070c, 16'h0710, 16'h0714, 16'h0718,
      16'h071c, 16'h0730, 16'h0734, 16'h0738, 16'h073c, 16'h0740, 16'h0744, 16'h0750, 16'h0754, 16'h0770,
      16'h0774, 16'h0780, 16'h0790, 16'h0794, 16'h0800, 16'h0804, 16'h0808, 16'h080c, 16'h0810, 16'h0830,
      16'h0834, 16'h0838, 16'h083c, 16'h0840, 16'h0844, 16'h0850, 16'h0854, 16'h0870, 16'h0874, 16'h0880,
      16'h0994, 16'h09a4};
   localparam logic [15:0] PTR [5] = '{16'h0718, 16'h071c, 16'h0740, 16'h0840, 16'h0810};
   localparam logic [15:0] QEND [5] = '{16'h0708, 16'h0708, 16'h0738, 16'h0838, 16'h0808};
   always #5 clk = ~clk;
   hdlc_dma_cfg hdlc_dma_cfg_inst (.*, .rx_free_large_adv(adv[0]), .rx_free_small_adv(adv[1]), .rx_done_adv(adv[2]),
      .tx_done_adv(adv[3]), .tx_pending_adv(adv[4]));
   fetch_sink fetch_sink_inst (.*);
   // ==========
   // Expectations
   function logic [15:0] msk(input logic [15:0] a);
      return (a == 16'h0790 || a == 16'h0794) ? 16'h1fff : (a == 16'h0994 || a == 16'h09a4) ? 16'h03ff : 16'hffff;
   endfunction
   function logic [8:0] burst(input logic [1:0] s);
      return 9'h020 << s;
   endfunction
   function logic [15:0] nxt(input logic [15:0] p, e);
      return (p == e) ? 16'h0000 : p + 16'h0001;
   endfunction
   function logic want(input logic en, input logic [9:0] m, bl);
      return en && m != 10'h000 && bl <= m;
   endfunction
   // ==========
   // Bus tasks and comparison
   task chk(input string what, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wr(input logic [15:0] a, dat);
      if (a == 16'h0010) ten = dat[1];
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= dat;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rchk(input logic [15:0] a, e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("read answer strobe", 32'h1, {31'h0, reg_rdata_valid});
      chk($sformatf("register %h", a), {16'h0, e}, {16'h0, reg_rdata});
   endtask
   task rep(input logic [7:0] ch, input logic [9:0] bl, m);
      @(posedge clk);
      tx_level_valid <= 1'b1;
      tx_level_ch <= ch;
      tx_level_blocks <= bl;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (tx_level_ready !== 1'b1 && n < 50);
      tx_level_valid <= 1'b0;
      if (want(ten, m, bl)) exp_q.push_back(ch);
      #1;
   endtask
   task drain;
      n = 0;
      while (fetch_sink_inst.got.size() < exp_q.size() && n < 300) begin
         @(posedge clk);
         n++;
      end
      chk("fetch count", exp_q.size(), fetch_sink_inst.got.size());
      foreach (exp_q[i]) chk("fetched channel", {24'h0, exp_q[i]}, {24'h0, fetch_sink_inst.got[i]});
      exp_q.delete();
      fetch_sink_inst.got.delete();
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      close_out();
   end
   // ==========
   // Tests
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (OFS[i]) rchk(OFS[i], 16'h0000);
      rchk(16'h09a0, 16'h0000);
      chk("enables and bursts", {2'b00, 9'h020, 9'h020}, {rx_dma_enable_bit, tx_dma_enable_bit, rx_burst_dwords,
         tx_burst_dwords});
      $display("test reset done");
      foreach (OFS[i]) begin
         v[i] = (i == 19) ? 16'hffff : (i == 20) ? 16'h0000 : 16'($random(seed));
         wr(OFS[i], v[i]);
         rchk(OFS[i], v[i] & msk(OFS[i]));
      end
      chk("rx base", {v[15], v[14]}, rx_desc_base);
      chk("tx base", {v[33], v[32]}, tx_desc_base);
      chk("sizes", {v[19][12:0], v[20][12:0]}, {rx_large_size, rx_small_size});
      chk("link", {22'h0, v[37][9:0]}, {22'h0, next_block_link});
      wr(16'h0720, 16'($random(seed)));
      rchk(16'h0720, 16'h0000);
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         wr(16'h0010, 16'(i * 16 + (3 - i) * 4 + 1));
         repeat (2) @(posedge clk);
         chk("bursts", {1'b1, 1'b0, burst(2'(3 - i)), burst(2'(i))}, {rx_dma_enable_bit, tx_dma_enable_bit,
            rx_burst_dwords, tx_burst_dwords});
      end
      $display("test master control done");
      ca = 8'($random(seed));
      cb = ca ^ 8'h80;
      ma = 10'h002 + 10'($unsigned($random(seed)) % 500);
      foreach (OFS[i]) if (i != 19 && i != 20) wr(OFS[i], 16'h0000);
      wr(16'h09a4, {6'h0, ma});
      wr(16'h09a0, {8'h00, ca});
      wr(16'h09a4, 16'h0003);
      wr(16'h09a0, {8'h00, cb});
      rchk(16'h09a0, {8'h00, cb});
      wr(16'h09a4, 16'h0000);
      wr(16'h09a0, {8'h40, ca});
      rchk(16'h09a4, {6'h0, ma});
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= 16'h09a0;
      reg_wdata <= {8'h40, cb};
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("busy during access", 32'h1, {31'h0, reg_rdata[15]});
      rchk(16'h09a0, {8'h40, cb});
      rchk(16'h09a4, 16'h0003);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= 16'h09a0;
      reg_wdata <= {8'h40, ca};
      @(posedge clk);
      reg_wdata <= {8'h00, cb};
      @(posedge clk);
      reg_wr <= 1'b0;
      rchk(16'h09a0, {8'h40, ca});
      rchk(16'h09a4, {6'h0, ma});
      $display("test indirect done");
      for (int i = 0; i < 5; i++) begin
         d = 16'h0010 + 16'($random(seed) & 8'hff);
         wr(QEND[i], d);
         v[0] = (i == 1) ? 16'h0003 : d - 16'h0001;
         wr(PTR[i], v[0]);
         repeat (2) begin
            @(posedge clk);
            adv <= 5'h01 << i;
            @(posedge clk);
            adv <= 5'h00;
            v[0] = nxt(v[0], d);
            rchk(PTR[i], v[0]);
         end
      end
      $display("test pointers done");
      wr(16'h0010, 16'h0002);
      rep(ca, ma, ma);
      rep(ca, ma + 10'h001, ma);
      rep(cb, 10'h000, 10'h003);
      rep(cb, 10'h004, 10'h003);
      drain();
      wr(16'h0010, 16'h0000);
      rep(ca, 10'h000, ma);
      drain();
      wr(16'h0010, 16'h0002);
      pace <= 2'd2;
      for (int i = 0; i < 8; i++) rep(i[0] ? ca : cb, 10'h001, i[0] ? ma : 10'h003);
      @(posedge clk);
      chk("level ready when full", 32'h0, {31'h0, tx_level_ready});
      pace <= 2'd1;
      drain();
      $display("test fetch done");
      close_out();
   end
endmodule
